// File: design/cspm_pkg.sv
package cspm_pkg;
	// core clock and derived timing
	localparam int CLK_HZ = 100_000_000;
	localparam int CLK_PERIOD_NS = 10;
	localparam int ACC_UNIT_HZ = 1_000_000;
	localparam int FAST_HZ = 24_000_000;
	localparam int MID_HZ = 12_000_000;
	localparam int SLOW_HZ = 6_000_000;
	localparam logic [7:0] ACC_MOD = 8'(CLK_HZ / ACC_UNIT_HZ);
	localparam int NUM_CLKS = 3;
	localparam int CLK_FAST = 0;
	localparam int CLK_MID = 1;
	localparam int CLK_SLOW = 2;
	// phase steps: the output toggles at twice its frequency
	localparam logic [7:0] CLK_STEP [NUM_CLKS] = '{
		8'(2 * FAST_HZ / ACC_UNIT_HZ),
		8'(2 * MID_HZ / ACC_UNIT_HZ),
		8'(2 * SLOW_HZ / ACC_UNIT_HZ)};
	// activity led pulse stretch, least time rounded up
	localparam int LED_PULSE_NS = 100;
	localparam logic [3:0] LED_PULSE_CYC =
		4'((LED_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam int NUM_LEDS = 3;
	localparam int LED_TX = 0;
	localparam int LED_RX = 1;
	localparam int LED_ANY = 2;
	// pin function codes
	localparam int FN_W = 5;
	typedef logic [FN_W-1:0] cspm_fn_t;
	localparam cspm_fn_t FN_TRISTATE = 5'h00;
	localparam cspm_fn_t FN_DRIVE_1 = 5'h01;
	localparam cspm_fn_t FN_DRIVE_0 = 5'h02;
	localparam cspm_fn_t FN_POWER_EN = 5'h03;
	localparam cspm_fn_t FN_TX_LED = 5'h04;
	localparam cspm_fn_t FN_RX_LED = 5'h05;
	localparam cspm_fn_t FN_ANY_LED = 5'h06;
	localparam cspm_fn_t FN_SLEEP = 5'h07;
	localparam cspm_fn_t FN_CLK_FAST = 5'h08;
	localparam cspm_fn_t FN_CLK_MID = 5'h09;
	localparam cspm_fn_t FN_CLK_SLOW = 5'h0A;
	localparam cspm_fn_t FN_CHARGER = 5'h0B;
	localparam cspm_fn_t FN_CHARGER_N = 5'h0C;
	localparam cspm_fn_t FN_BB_WRITE = 5'h0D;
	localparam cspm_fn_t FN_BB_READ = 5'h0E;
	localparam cspm_fn_t FN_BUS_SENSE = 5'h0F;
	localparam cspm_fn_t FN_TIMESTAMP = 5'h10;
	localparam cspm_fn_t FN_KEEP_AWAKE = 5'h11;
	// pins
	localparam int NUM_PINS = 2;
	localparam int PIN_A = 0;
	localparam int PIN_B = 1;
	// register map
	localparam logic [7:0] REG_CFG = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam int CFG_A_LSB = 0;
	localparam int CFG_B_LSB = 8;
	localparam int CFG_OVR_BIT = 16;
	localparam cspm_fn_t CFG_A_RST = FN_BUS_SENSE;
	localparam cspm_fn_t CFG_B_RST = FN_KEEP_AWAKE;
	localparam logic CFG_OVR_RST = 1'b0;
	localparam int ST_CONFIGURED = 0;
	localparam int ST_SUSPEND = 1;
	localparam int ST_CHARGER = 2;
	localparam int ST_BUS_POWER = 3;
	localparam int ST_KEEP_AWAKE = 4;
	localparam int ST_PIN_A = 5;
	localparam int ST_PIN_B = 6;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {SEL_NONE, SEL_CFG, SEL_STATUS} cspm_reg_e;
endpackage

// File: design/cspm_clk_div.sv
`timescale 1ns/1ns
// fractional divider: average rate is exact, edges jitter by one core cycle
module cspm_clk_div (
	input wire logic mclk_i, // core clock
	input wire logic rst_n_i, // sync reset, active low
	input wire logic run_i, // high lets the clock run
	input wire logic [7:0] step_i, // phase step per core cycle
	output logic clk_o // divided clock
);
	logic [7:0] acc_reg;
	logic [8:0] sum;
	logic clk_reg;

	// wrap of the phase accumulator marks a half period
	assign sum = {1'b0, acc_reg} + {1'b0, step_i};

	// holding the accumulator freezes the clock level while stopped
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			acc_reg <= 8'h00;
			clk_reg <= 1'b0;
		end else if (run_i) begin
			if (sum >= {1'b0, cspm_pkg::ACC_MOD}) begin
				acc_reg <= 8'(sum - {1'b0, cspm_pkg::ACC_MOD});
				clk_reg <= ~clk_reg;
			end else begin
				acc_reg <= sum[7:0];
			end
		end
	end

	assign clk_o = clk_reg;
endmodule // cspm_clk_div

// File: design/cspm_top.sv
// Implementation choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ns
// Summary of operation
// - tristate releases the pad; drive options hold a constant 1 or 0
// - power enable low once usb configured, released high in suspend
// - power enable is open drain only, never drives high
// - transmit led pulses the open drain pin low on transmit activity
// - receive led pulses the open drain pin low on receive activity
// - combined led pulses low on activity in either direction
// - sleep indicator low during suspend, high otherwise
// - optional override forces sleep indicator high on a charger port
// - clock outputs at 24, 12 or 6 MHz, stopped in suspend
// - active high charger detect drives high on a charger port
// - active low charger detect pulls low, open drain, on a charger
// - bit-bang write strobe function passes the engine write strobe
// - bit-bang read strobe function passes the engine read strobe
// - bus power sense pin is an input sampled for bus power
// - timestamp pin inverts on each start of frame
// - keep awake is an active low input that blocks suspend
// - each pin function comes from the stored configuration
// - second pin defaults to keep awake
// - first pin defaults to bus power sense
module cspm_top (
	input wire logic mclk_i, // core clock, 100 MHz
	input wire logic rst_n_i, // sync reset, active low
	input wire logic [7:0] s_axi_awaddr_i, // write address
	input wire logic s_axi_awvalid_i, // write address valid
	output logic s_axi_awready_o, // write address ready
	input wire logic [31:0] s_axi_wdata_i, // write data
	input wire logic [3:0] s_axi_wstrb_i, // write byte strobes
	input wire logic s_axi_wvalid_i, // write data valid
	output logic s_axi_wready_o, // write data ready
	output logic [1:0] s_axi_bresp_o, // write response
	output logic s_axi_bvalid_o, // write response valid
	input wire logic s_axi_bready_i, // write response ready
	input wire logic [7:0] s_axi_araddr_i, // read address
	input wire logic s_axi_arvalid_i, // read address valid
	output logic s_axi_arready_o, // read address ready
	output logic [31:0] s_axi_rdata_o, // read data
	output logic [1:0] s_axi_rresp_o, // read response
	output logic s_axi_rvalid_o, // read data valid
	input wire logic s_axi_rready_i, // read data ready
	input wire logic usb_configured_i, // host finished configuration
	input wire logic usb_suspend_i, // usb suspend in effect
	input wire logic charger_detect_i, // dedicated charger port seen
	input wire logic tx_active_i, // data sent to host this cycle
	input wire logic rx_active_i, // data received from host this cycle
	input wire logic sof_i, // start of frame received, pulse
	input wire logic bitbang_write_strobe_n_i, // engine write strobe
	input wire logic bitbang_read_strobe_n_i, // engine read strobe
	input wire logic config_pin_a_i, // pad level, first pin
	output logic config_pin_a_o, // pad drive, first pin
	output logic config_pin_a_oe_o, // pad enable, first pin
	input wire logic config_pin_b_i, // pad level, second pin
	output logic config_pin_b_o, // pad drive, second pin
	output logic config_pin_b_oe_o, // pad enable, second pin
	output logic bus_power_sense_o, // bus power present
	output logic keep_awake_o // suspend must be held off
);
	cspm_pkg::cspm_fn_t sel_reg [cspm_pkg::NUM_PINS];
	logic ovr_reg;
	logic [cspm_pkg::NUM_PINS-1:0] pin_i, out_reg, oe_reg;
	logic [cspm_pkg::NUM_CLKS-1:0] clk_div;
	logic [cspm_pkg::NUM_LEDS-1:0] led_act, led_on;
	logic ts_reg, bus_power_reg, keep_awake_reg;
	logic pwr_on, sleep_hi;
	logic aw_rdy_reg, aw_got_reg, w_rdy_reg, w_got_reg, bvalid_reg, ar_rdy_reg, rvalid_reg;
	logic [7:0] awaddr_reg;
	logic [31:0] wdata_reg, rdata_reg;
	logic [3:0] wstrb_reg;
	logic [1:0] bresp_reg, rresp_reg;
	logic do_wr;

	// address decode shared by the read and write paths
	function automatic cspm_pkg::cspm_reg_e reg_sel(input logic [7:0] addr);
		case (addr)
			cspm_pkg::REG_CFG: reg_sel = cspm_pkg::SEL_CFG;
			cspm_pkg::REG_STATUS: reg_sel = cspm_pkg::SEL_STATUS;
			default: reg_sel = cspm_pkg::SEL_NONE;
		endcase
	endfunction

	// per-pin output mux, returns {enable, level}; inputs never drive
	function automatic logic [1:0] pin_drive(
		input cspm_pkg::cspm_fn_t fn,
		input logic pwr,
		input logic [cspm_pkg::NUM_LEDS-1:0] led,
		input logic slp,
		input logic [cspm_pkg::NUM_CLKS-1:0] clks,
		input logic chg,
		input logic bbw,
		input logic bbr,
		input logic ts);
		case (fn)
			cspm_pkg::FN_TRISTATE: pin_drive = 2'h0;
			cspm_pkg::FN_DRIVE_1: pin_drive = 2'h3;
			cspm_pkg::FN_DRIVE_0: pin_drive = 2'h2;
			cspm_pkg::FN_POWER_EN: pin_drive = {pwr, 1'b0};
			cspm_pkg::FN_TX_LED: pin_drive = {led[cspm_pkg::LED_TX], 1'b0};
			cspm_pkg::FN_RX_LED: pin_drive = {led[cspm_pkg::LED_RX], 1'b0};
			cspm_pkg::FN_ANY_LED: pin_drive = {led[cspm_pkg::LED_ANY], 1'b0};
			cspm_pkg::FN_SLEEP: pin_drive = {1'b1, slp};
			cspm_pkg::FN_CLK_FAST: pin_drive = {1'b1, clks[cspm_pkg::CLK_FAST]};
			cspm_pkg::FN_CLK_MID: pin_drive = {1'b1, clks[cspm_pkg::CLK_MID]};
			cspm_pkg::FN_CLK_SLOW: pin_drive = {1'b1, clks[cspm_pkg::CLK_SLOW]};
			cspm_pkg::FN_CHARGER: pin_drive = {1'b1, chg};
			cspm_pkg::FN_CHARGER_N: pin_drive = {chg, 1'b0};
			cspm_pkg::FN_BB_WRITE: pin_drive = {1'b1, bbw};
			cspm_pkg::FN_BB_READ: pin_drive = {1'b1, bbr};
			cspm_pkg::FN_TIMESTAMP: pin_drive = {1'b1, ts};
			default: pin_drive = 2'h0; // sense, keep awake, unused codes
		endcase
	endfunction

	// ---------------- register bus, write side ----------------
	assign do_wr = aw_got_reg && w_got_reg && !bvalid_reg;

	// address and data are taken independently, in either order
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			aw_rdy_reg <= 1'b0;
			aw_got_reg <= 1'b0;
			awaddr_reg <= 8'h00;
		end else if (s_axi_awvalid_i && aw_rdy_reg) begin
			aw_rdy_reg <= 1'b0;
			aw_got_reg <= 1'b1;
			awaddr_reg <= s_axi_awaddr_i;
		end else if (bvalid_reg && s_axi_bready_i) begin
			aw_rdy_reg <= 1'b1;
			aw_got_reg <= 1'b0;
		end else if (!aw_got_reg && !bvalid_reg) begin
			aw_rdy_reg <= 1'b1;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			w_rdy_reg <= 1'b0;
			w_got_reg <= 1'b0;
			wdata_reg <= 32'h0000_0000;
			wstrb_reg <= 4'h0;
		end else if (s_axi_wvalid_i && w_rdy_reg) begin
			w_rdy_reg <= 1'b0;
			w_got_reg <= 1'b1;
			wdata_reg <= s_axi_wdata_i;
			wstrb_reg <= s_axi_wstrb_i;
		end else if (bvalid_reg && s_axi_bready_i) begin
			w_rdy_reg <= 1'b1;
			w_got_reg <= 1'b0;
		end else if (!w_got_reg && !bvalid_reg) begin
			w_rdy_reg <= 1'b1;
		end
	end

	// response once both halves are in; unmapped offsets get slverr
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			bvalid_reg <= 1'b0;
			bresp_reg <= cspm_pkg::RESP_OKAY;
		end else if (do_wr) begin
			bvalid_reg <= 1'b1;
			bresp_reg <= (reg_sel(awaddr_reg) == cspm_pkg::SEL_NONE) ?
				cspm_pkg::RESP_SLVERR : cspm_pkg::RESP_OKAY;
		end else if (s_axi_bready_i) begin
			bvalid_reg <= 1'b0;
		end
	end

	// function selection; reset loads the factory defaults, software
	// copies the stored configuration image in after power-up
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			sel_reg[cspm_pkg::PIN_A] <= cspm_pkg::CFG_A_RST;
			sel_reg[cspm_pkg::PIN_B] <= cspm_pkg::CFG_B_RST;
			ovr_reg <= cspm_pkg::CFG_OVR_RST;
		end else if (do_wr && reg_sel(awaddr_reg) == cspm_pkg::SEL_CFG) begin
			if (wstrb_reg[cspm_pkg::CFG_A_LSB/8]) begin
				sel_reg[cspm_pkg::PIN_A] <= wdata_reg[cspm_pkg::CFG_A_LSB +: cspm_pkg::FN_W];
			end
			if (wstrb_reg[cspm_pkg::CFG_B_LSB/8]) begin
				sel_reg[cspm_pkg::PIN_B] <= wdata_reg[cspm_pkg::CFG_B_LSB +: cspm_pkg::FN_W];
			end
			if (wstrb_reg[cspm_pkg::CFG_OVR_BIT/8]) begin
				ovr_reg <= wdata_reg[cspm_pkg::CFG_OVR_BIT];
			end
		end
	end

	// ---------------- register bus, read side ----------------
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			ar_rdy_reg <= 1'b0;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			rresp_reg <= cspm_pkg::RESP_OKAY;
		end else if (s_axi_arvalid_i && ar_rdy_reg) begin
			ar_rdy_reg <= 1'b0;
			rvalid_reg <= 1'b1;
			rdata_reg <= 32'h0000_0000;
			rresp_reg <= cspm_pkg::RESP_OKAY;
			case (reg_sel(s_axi_araddr_i))
				cspm_pkg::SEL_CFG: begin
					rdata_reg[cspm_pkg::CFG_A_LSB +: cspm_pkg::FN_W] <= sel_reg[cspm_pkg::PIN_A];
					rdata_reg[cspm_pkg::CFG_B_LSB +: cspm_pkg::FN_W] <= sel_reg[cspm_pkg::PIN_B];
					rdata_reg[cspm_pkg::CFG_OVR_BIT] <= ovr_reg;
				end
				cspm_pkg::SEL_STATUS: begin
					rdata_reg[cspm_pkg::ST_CONFIGURED] <= usb_configured_i;
					rdata_reg[cspm_pkg::ST_SUSPEND] <= usb_suspend_i;
					rdata_reg[cspm_pkg::ST_CHARGER] <= charger_detect_i;
					rdata_reg[cspm_pkg::ST_BUS_POWER] <= bus_power_reg;
					rdata_reg[cspm_pkg::ST_KEEP_AWAKE] <= keep_awake_reg;
					rdata_reg[cspm_pkg::ST_PIN_A] <= config_pin_a_i;
					rdata_reg[cspm_pkg::ST_PIN_B] <= config_pin_b_i;
				end
				default: rresp_reg <= cspm_pkg::RESP_SLVERR;
			endcase
		end else if (rvalid_reg && s_axi_rready_i) begin
			rvalid_reg <= 1'b0;
			ar_rdy_reg <= 1'b1;
		end else if (!rvalid_reg) begin
			ar_rdy_reg <= 1'b1;
		end
	end

	// ---------------- function sources ----------------
	assign pwr_on = usb_configured_i && !usb_suspend_i;
	// charger override wins so a charger-only port never looks asleep
	assign sleep_hi = !usb_suspend_i || (ovr_reg && charger_detect_i);
	assign led_act = {tx_active_i || rx_active_i, rx_active_i, tx_active_i};

	// divided clocks stop in suspend and hold their level
	generate
		for (genvar c = 0; c < cspm_pkg::NUM_CLKS; c++) begin : g_clk
			cspm_clk_div u_div (
				.mclk_i(mclk_i),
				.rst_n_i(rst_n_i),
				.run_i(!usb_suspend_i),
				.step_i(cspm_pkg::CLK_STEP[c]),
				.clk_o(clk_div[c])
			);
		end
	endgenerate

	// stretch one-cycle activity so an led pulse is long enough to see
	generate
		for (genvar l = 0; l < cspm_pkg::NUM_LEDS; l++) begin : g_led
			logic [3:0] cnt_reg;
			always_ff @(posedge mclk_i) begin
				if (!rst_n_i) begin
					cnt_reg <= 4'h0;
				end else if (led_act[l]) begin
					cnt_reg <= cspm_pkg::LED_PULSE_CYC;
				end else if (cnt_reg != 4'h0) begin
					cnt_reg <= cnt_reg - 4'h1;
				end
			end
			assign led_on[l] = (cnt_reg != 4'h0);
		end
	endgenerate

	// frame marker toggles on each start of frame
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			ts_reg <= 1'b0;
		end else if (sof_i) begin
			ts_reg <= ~ts_reg;
		end
	end

	// ---------------- pin muxes ----------------
	assign pin_i = {config_pin_b_i, config_pin_a_i};

	generate
		for (genvar p = 0; p < cspm_pkg::NUM_PINS; p++) begin : g_pin
			always_ff @(posedge mclk_i) begin
				if (!rst_n_i) begin
					{oe_reg[p], out_reg[p]} <= 2'h0;
				end else begin
					{oe_reg[p], out_reg[p]} <= pin_drive(sel_reg[p], pwr_on, led_on, sleep_hi,
						clk_div, charger_detect_i, bitbang_write_strobe_n_i,
						bitbang_read_strobe_n_i, ts_reg);
				end
			end
		end
	endgenerate

	// inputs: only a pin holding that function is sampled; with no sense
	// pin selected bus power is taken as present
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			bus_power_reg <= 1'b1;
			keep_awake_reg <= 1'b0;
		end else begin
			bus_power_reg <= (sel_reg[cspm_pkg::PIN_A] == cspm_pkg::FN_BUS_SENSE) ? pin_i[cspm_pkg::PIN_A] :
				(sel_reg[cspm_pkg::PIN_B] == cspm_pkg::FN_BUS_SENSE) ? pin_i[cspm_pkg::PIN_B] :
				1'b1;
			keep_awake_reg <=
				((sel_reg[cspm_pkg::PIN_A] == cspm_pkg::FN_KEEP_AWAKE) && !pin_i[cspm_pkg::PIN_A]) ||
				((sel_reg[cspm_pkg::PIN_B] == cspm_pkg::FN_KEEP_AWAKE) && !pin_i[cspm_pkg::PIN_B]);
		end
	end

	assign config_pin_a_o = out_reg[cspm_pkg::PIN_A];
	assign config_pin_a_oe_o = oe_reg[cspm_pkg::PIN_A];
	assign config_pin_b_o = out_reg[cspm_pkg::PIN_B];
	assign config_pin_b_oe_o = oe_reg[cspm_pkg::PIN_B];
	assign bus_power_sense_o = bus_power_reg;
	assign keep_awake_o = keep_awake_reg;
	assign s_axi_awready_o = aw_rdy_reg;
	assign s_axi_wready_o = w_rdy_reg;
	assign s_axi_bvalid_o = bvalid_reg;
	assign s_axi_bresp_o = bresp_reg;
	assign s_axi_arready_o = ar_rdy_reg;
	assign s_axi_rvalid_o = rvalid_reg;
	assign s_axi_rdata_o = rdata_reg;
	assign s_axi_rresp_o = rresp_reg;

	// ---------------- checks ----------------
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);
	logic [cspm_pkg::FN_W-1:0] fa;
	assign fa = sel_reg[cspm_pkg::PIN_A];

	property p_tristate;
		fa == cspm_pkg::FN_TRISTATE |=> !config_pin_a_oe_o;
	endproperty
	a_tristate: assert property (p_tristate) else $error("tristate pin driven");
	property p_drive;
		fa == cspm_pkg::FN_DRIVE_0 |=> config_pin_a_oe_o && !config_pin_a_o;
	endproperty
	a_drive: assert property (p_drive) else $error("drive 0 wrong");
	property p_power_on;
		fa == cspm_pkg::FN_POWER_EN && usb_configured_i && !usb_suspend_i
			|=> config_pin_a_oe_o && !config_pin_a_o;
	endproperty
	a_power_on: assert property (p_power_on) else $error("power enable not low");
	property p_power_od;
		fa == cspm_pkg::FN_POWER_EN |=> !(config_pin_a_oe_o && config_pin_a_o)
			&& (config_pin_a_oe_o == ($past(usb_configured_i) && !$past(usb_suspend_i)));
	endproperty
	a_power_od: assert property (p_power_od) else $error("power enable drove high");
	property p_tx_led;
		(fa == cspm_pkg::FN_TX_LED && tx_active_i) ##1 fa == cspm_pkg::FN_TX_LED
			|=> config_pin_a_oe_o && !config_pin_a_o;
	endproperty
	a_tx_led: assert property (p_tx_led) else $error("tx led missed");
	property p_any_led;
		(fa == cspm_pkg::FN_ANY_LED && rx_active_i) ##1 fa == cspm_pkg::FN_ANY_LED
			|=> config_pin_a_oe_o && !config_pin_a_o;
	endproperty
	a_any_led: assert property (p_any_led) else $error("any led missed");
	property p_sleep;
		fa == cspm_pkg::FN_SLEEP |=> config_pin_a_oe_o &&
			config_pin_a_o == (!$past(usb_suspend_i) || ($past(ovr_reg) && $past(charger_detect_i)));
	endproperty
	a_sleep: assert property (p_sleep) else $error("sleep level wrong");
	property p_clk_stop;
		(fa == cspm_pkg::FN_CLK_FAST && usb_suspend_i) [*2] |=> $stable(config_pin_a_o);
	endproperty
	a_clk_stop: assert property (p_clk_stop) else $error("clock ran in suspend");
	property p_charger_n;
		fa == cspm_pkg::FN_CHARGER_N |=> !config_pin_a_o &&
			config_pin_a_oe_o == $past(charger_detect_i);
	endproperty
	a_charger_n: assert property (p_charger_n) else $error("charger low wrong");
	property p_timestamp;
		(fa == cspm_pkg::FN_TIMESTAMP && sof_i) ##1 fa == cspm_pkg::FN_TIMESTAMP
			|=> $changed(config_pin_a_o);
	endproperty
	a_timestamp: assert property (p_timestamp) else $error("timestamp did not toggle");
	// the sense register still shows its reset level one edge after release
	property p_sense;
		rst_n_i && fa == cspm_pkg::FN_BUS_SENSE |=> !config_pin_a_oe_o &&
			bus_power_sense_o == $past(config_pin_a_i);
	endproperty
	a_sense: assert property (p_sense) else $error("bus sense wrong");
	property p_defaults;
		$rose(rst_n_i) |-> fa == cspm_pkg::CFG_A_RST && sel_reg[cspm_pkg::PIN_B] == cspm_pkg::CFG_B_RST;
	endproperty
	a_defaults: assert property (disable iff (1'b0) p_defaults)
		else $error("bad defaults");
	c_keep_awake: cover property (keep_awake_o);
	c_power_on: cover property (fa == cspm_pkg::FN_POWER_EN && pwr_on ##2 !config_pin_a_o);
	c_write_cfg: cover property (do_wr && reg_sel(awaddr_reg) == cspm_pkg::SEL_CFG);
endmodule // cspm_top

// File: test/cspm_ext_model.sv
`timescale 1ns/1ns
// far side of both pads: board pull-ups plus external logic for the input functions
module cspm_ext_model (
	input wire logic oe_a_i, // design enable, pin a
	input wire logic o_a_i, // design level, pin a
	input wire logic oe_b_i, // design enable, pin b
	input wire logic o_b_i, // design level, pin b
	input wire logic drv_i, // external logic drives the pads
	input wire logic [1:0] lvl_i, // external levels, b then a
	output logic pad_a_o, // resolved level, pin a
	output logic pad_b_o // resolved level, pin b
);
	// a released pad shows the external level, or the pull-up when drv_i is low, so a stale drive value can never pass
	assign pad_a_o = oe_a_i ? o_a_i : (drv_i ? lvl_i[0] : 1'b1);
	assign pad_b_o = oe_b_i ? o_b_i : (drv_i ? lvl_i[1] : 1'b1);
endmodule // cspm_ext_model

// File: test/cspm_top_tb.sv
`timescale 1ns/1ns
module cspm_top_tb;
	logic clk = 0, rst_n = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
	logic conf = 0, susp = 0, chg = 0, txa = 0, rxa = 0, sof = 0, bbw = 1, bbr = 1, drv = 1;
	logic [1:0] lvl = 2'h0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic awr, wrdy, bv, arr, rv, oe_a, o_a, oe_b, o_b, pad_a, pad_b, bps, kaw;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	int failures = 0, tests_run = 0;
	cspm_pkg::cspm_fn_t fl [9] = '{cspm_pkg::FN_TRISTATE, cspm_pkg::FN_DRIVE_1,
		cspm_pkg::FN_DRIVE_0, cspm_pkg::FN_POWER_EN, cspm_pkg::FN_SLEEP, cspm_pkg::FN_CHARGER,
		cspm_pkg::FN_CHARGER_N, cspm_pkg::FN_BB_WRITE, cspm_pkg::FN_BB_READ};
	// expected {enable, pad}: awake on a charger, then suspended on a host
	logic [1:0] e1 [9] = '{2'h1, 2'h3, 2'h2, 2'h2, 2'h3, 2'h3, 2'h2, 2'h2, 2'h3};
	logic [1:0] e2 [9] = '{2'h1, 2'h3, 2'h2, 2'h1, 2'h2, 2'h2, 2'h1, 2'h3, 2'h2};

	// 100 MHz core clock
	always #5 clk = ~clk;

	cspm_top dut_u (.mclk_i(clk), .rst_n_i(rst_n), .s_axi_awaddr_i(awaddr),
		.s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wdata),
		.s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrdy),
		.s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv), .s_axi_bready_i(bready),
		.s_axi_araddr_i(araddr), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
		.s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv),
		.s_axi_rready_i(rready), .usb_configured_i(conf), .usb_suspend_i(susp),
		.charger_detect_i(chg), .tx_active_i(txa), .rx_active_i(rxa), .sof_i(sof),
		.bitbang_write_strobe_n_i(bbw), .bitbang_read_strobe_n_i(bbr),
		.config_pin_a_i(pad_a), .config_pin_a_o(o_a), .config_pin_a_oe_o(oe_a),
		.config_pin_b_i(pad_b), .config_pin_b_o(o_b), .config_pin_b_oe_o(oe_b),
		.bus_power_sense_o(bps), .keep_awake_o(kaw));

	cspm_ext_model ext_u (.oe_a_i(oe_a), .o_a_i(o_a), .oe_b_i(oe_b), .o_b_i(o_b),
		.drv_i(drv), .lvl_i(lvl), .pad_a_o(pad_a), .pad_b_o(pad_b));

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		awaddr <= a;
		wdata <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awr) awv <= 1'b0;
			if (wrdy) wv <= 1'b0;
		end while (!bv);
		bready <= 1'b0;
		chk(32'(bresp), 32'(er));
	endtask

	task automatic rdr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		araddr <= a;
		arv <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arr) arv <= 1'b0;
		end while (!rv);
		rready <= 1'b0;
		chk(rdata, ed);
		chk(32'(rresp), 32'(er));
	endtask

	task automatic setcfg(input cspm_pkg::cspm_fn_t a, input cspm_pkg::cspm_fn_t b, input logic o);
		wr(cspm_pkg::REG_CFG, {8'h00, 7'h00, o, 3'h0, b, 3'h0, a}, cspm_pkg::RESP_OKAY);
		repeat (4) @(posedge clk);
	endtask

	// a write to the read-only status word must leave the defaults alone
	task automatic t_reset;
		wr(cspm_pkg::REG_STATUS, 32'hFFFF_FFFF, cspm_pkg::RESP_OKAY);
		rdr(cspm_pkg::REG_CFG, 32'h0000_110F, cspm_pkg::RESP_OKAY);
		chk(32'({oe_a, oe_b}), 32'h0000_0000);
		lvl <= 2'h1;
		repeat (3) @(posedge clk);
		chk(32'({bps, kaw}), 32'h0000_0003);
		lvl <= 2'h2;
		repeat (3) @(posedge clk);
		chk(32'({bps, kaw}), 32'h0000_0000);
		rdr(cspm_pkg::REG_STATUS, 32'h0000_0001 << cspm_pkg::ST_PIN_B, cspm_pkg::RESP_OKAY);
		rdr(8'h08, 32'h0000_0000, cspm_pkg::RESP_SLVERR);
		wr(8'h0C, 32'h0000_0000, cspm_pkg::RESP_SLVERR);
		drv <= 1'b0;
	endtask

	task automatic t_static(input logic s);
		for (int i = 0; i < 9; i++) begin
			setcfg(fl[i], fl[i], 1'b0);
			chk(32'({oe_a, pad_a}), 32'(s ? e2[i] : e1[i]));
			chk(32'({oe_b, pad_b}), 32'(s ? e2[i] : e1[i]));
		end
	endtask

	// one cycle of traffic, then the stretched pulse and its end
	task automatic t_led(input logic tx, input logic [1:0] e);
		txa <= tx;
		rxa <= !tx;
		@(posedge clk);
		txa <= 1'b0;
		rxa <= 1'b0;
		repeat (3) @(posedge clk);
		chk(32'({pad_b, pad_a}), 32'(e));
		repeat (20) @(posedge clk);
		chk(32'({pad_b, pad_a}), 32'h0000_0003);
	endtask

	task automatic t_ts;
		logic [1:0] p;
		p = {pad_b, pad_a};
		sof <= 1'b1;
		@(posedge clk);
		sof <= 1'b0;
		repeat (3) @(posedge clk);
		chk(32'({pad_b, pad_a}), 32'({~p}));
	endtask

	// rising edges on pin a over a span of core cycles
	task automatic t_clk(input int cyc, input int e);
		int n;
		logic p;
		n = 0;
		p = pad_a;
		repeat (cyc) begin
			@(posedge clk);
			if (pad_a && !p) n++;
			p = pad_a;
		end
		chk(32'(n >= e - 1 && n <= e + 1), 32'h0000_0001);
	endtask

	// charger in suspend: sleep low without the override, high with it
	task automatic t_ovr;
		chg <= 1'b1;
		setcfg(cspm_pkg::FN_SLEEP, cspm_pkg::FN_SLEEP, 1'b0);
		chk(32'({pad_b, pad_a}), 32'h0000_0000);
		setcfg(cspm_pkg::FN_SLEEP, cspm_pkg::FN_SLEEP, 1'b1);
		chk(32'({pad_b, pad_a}), 32'h0000_0003);
	endtask

	// a suspended clock holds still, then each rate runs in turn
	task automatic t_clocks;
		setcfg(cspm_pkg::FN_CLK_FAST, cspm_pkg::FN_CLK_FAST, 1'b0);
		t_clk(200, 0);
		susp <= 1'b0;
		for (int k = 0; k < 3; k++) begin
			setcfg(5'(cspm_pkg::FN_CLK_FAST + k), cspm_pkg::FN_DRIVE_1, 1'b0);
			t_clk(1000, 240 >> k);
		end
	endtask

	task automatic complete_run;
		$display("checks %0d failures %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	// main sequence
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		t_reset;
		conf <= 1'b1;
		chg <= 1'b1;
		bbw <= 1'b0;
		t_static(1'b0);
		susp <= 1'b1;
		chg <= 1'b0;
		bbw <= 1'b1;
		bbr <= 1'b0;
		t_static(1'b1);
		t_ovr;
		t_clocks;
		setcfg(cspm_pkg::FN_TX_LED, cspm_pkg::FN_RX_LED, 1'b0);
		t_led(1'b1, 2'h2);
		t_led(1'b0, 2'h1);
		setcfg(cspm_pkg::FN_ANY_LED, cspm_pkg::FN_ANY_LED, 1'b0);
		t_led(1'b0, 2'h0);
		t_led(1'b1, 2'h0);
		setcfg(cspm_pkg::FN_TIMESTAMP, cspm_pkg::FN_TIMESTAMP, 1'b0);
		t_ts;
		t_ts;
		complete_run;
	end

	// watchdog: the sequence needs well under ten thousand cycles
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		complete_run;
	end
endmodule // cspm_top_tb
